// ### rtl/acc_top.sv
// converter control: channel select, clock select, conversion sequencing, bus slave
module acc_top #(
   parameter int RC_HALF = acc_pkg::ACC_RC_HALF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // axi4-lite write
   input wire logic [9:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   // axi4-lite read
   input wire logic [9:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // analog macro
   output acc_pkg::acc_analog_t analog_o,
   input wire logic [9:0] sar_result_i,
   // interrupt
   output logic irq_o
);
   import acc_pkg::*;

   // ===================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ===================================================
   // write channel capture: address and data in either order
   logic [9:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q, w_have_q;
   logic do_write;
   logic wr_hit;
   assign do_write = aw_have_q && w_have_q && !s_bvalid_o;
   // ready outputs are flops that always hold the inverse of the holding flags
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         s_awready_o <= 1'b1;
         s_wready_o <= 1'b1;
         awaddr_q <= 10'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_bvalid_o <= 1'b0;
         s_bresp_o <= ACC_RESP_OKAY;
      end
      else
      begin
         if (s_awvalid_i && s_awready_o)
         begin
            aw_have_q <= 1'b1;
            s_awready_o <= 1'b0;
            awaddr_q <= s_awaddr_i;
         end
         if (s_wvalid_i && s_wready_o)
         begin
            w_have_q <= 1'b1;
            s_wready_o <= 1'b0;
            wdata_q <= s_wdata_i;
            wstrb_q <= s_wstrb_i;
         end
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_awready_o <= 1'b1;
            s_wready_o <= 1'b1;
            s_bvalid_o <= 1'b1;
            s_bresp_o <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
         end
         else if (s_bvalid_o && s_bready_i)
            s_bvalid_o <= 1'b0;
      end
   end

   // write decode
   logic wr_ctrl, wr_clk, wr_en, wr_clr;
   assign wr_ctrl = do_write && awaddr_q == ACC_CTRL_ADDR && wstrb_q[0];
   assign wr_clk = do_write && awaddr_q == ACC_CLKSEL_ADDR && wstrb_q[0];
   assign wr_en = do_write && awaddr_q == ACC_IRQ_ENABLE_ADDR && wstrb_q[0];
   assign wr_clr = do_write && awaddr_q == ACC_IRQ_CLEAR_ADDR && wstrb_q[0];
   assign wr_hit = awaddr_q == ACC_CTRL_ADDR || awaddr_q == ACC_CLKSEL_ADDR
      || awaddr_q == ACC_IRQ_ENABLE_ADDR || awaddr_q == ACC_IRQ_CLEAR_ADDR
      || awaddr_q == ACC_RESULT_ADDR || awaddr_q == ACC_IRQ_STATUS_ADDR;

   // ===================================================
   // control and clock select registers
   logic [7:0] ctrl_q, clksel_q;
   logic done_ev;
   logic [2:0] conv_clock_field;
   logic [2:0] input_channel_field;
   logic converter_enable, go_bit;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q <= ACC_CTRL_RESET;
         clksel_q <= ACC_CLKSEL_RESET;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= wdata_q[7:0] & ACC_CTRL_MASK;
         if (done_ev)
            ctrl_q[ACC_GO_BIT] <= 1'b0;
         if (wr_clk)
            clksel_q <= wdata_q[7:0] & ACC_CLKSEL_MASK;
      end
   end
   assign converter_enable = ctrl_q[ACC_ENABLE_BIT];
   assign go_bit = ctrl_q[ACC_GO_BIT];
   assign input_channel_field = ctrl_q[ACC_CHAN_LSB +: 3];
   assign conv_clock_field = clksel_q[ACC_CLK_LSB +: 3];

   // ===================================================
   // conversion clock: oscillator divider or internal rc
   logic [5:0] div_q;
   logic [$clog2(RC_HALF+1)-1:0] rc_cnt_q;
   logic rc_q, rc_prev_q, rc_tick;
   logic [5:0] div_mask;
   logic bit_tick;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q <= 6'h00;
         rc_cnt_q <= '0;
         rc_q <= 1'b0;
         rc_prev_q <= 1'b0;
      end
      else
      begin
         div_q <= div_q + 6'h01;
         rc_prev_q <= rc_q;
         if (rc_cnt_q == ($clog2(RC_HALF+1))'(RC_HALF - 1))
         begin
            rc_cnt_q <= '0;
            rc_q <= !rc_q;
         end
         else
            rc_cnt_q <= rc_cnt_q + 1'b1;
      end
   end
   assign rc_tick = rc_q && !rc_prev_q;
   // mask picks divide ratio
   assign div_mask = conv_clock_field == 3'h0 ? 6'h01 :
                     conv_clock_field == 3'h1 ? 6'h07 :
                     conv_clock_field == 3'h2 ? 6'h1f :
                     conv_clock_field == 3'h4 ? 6'h03 :
                     conv_clock_field == 3'h5 ? 6'h0f :
                     6'h3f;
   assign bit_tick = conv_clock_field[1:0] == 2'b11 ? rc_tick
                                                    : (div_q & div_mask) == div_mask;

   // ===================================================
   // conversion sequencer
   acc_state_t state_q;
   logic [3:0] period_q;
   logic [9:0] result_q;
   logic analog_bit_q;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ACC_IDLE;
         period_q <= 4'h0;
         analog_bit_q <= 1'b0;
      end
      else
      begin
         analog_bit_q <= 1'b0;
         case (state_q)
            ACC_IDLE:
               if (go_bit && converter_enable)
               begin
                  state_q <= ACC_CONV;
                  period_q <= 4'h0;
               end
            ACC_CONV:
               if (!go_bit || !converter_enable)
                  state_q <= ACC_IDLE;
               else if (bit_tick)
               begin
                  analog_bit_q <= 1'b1;
                  period_q <= period_q + 4'h1;
                  if (period_q == 4'(ACC_CONV_PERIODS - 1))
                     state_q <= ACC_IDLE;
               end
            default:
               state_q <= ACC_IDLE;
         endcase
      end
   end
   assign done_ev = state_q == ACC_CONV && go_bit && converter_enable && bit_tick
                    && period_q == 4'(ACC_CONV_PERIODS - 1);

   // results survive reset: no reset branch
   always_ff @(posedge clk_i)
   begin
      if (done_ev)
         result_q <= sar_result_i;
   end

   // ===================================================
   // interrupt status, enable, clear
   logic status_q, enable_q;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_q <= 1'b0;
         enable_q <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         if (done_ev)
            status_q <= 1'b1;
         else if (wr_clr && wdata_q[0])
            status_q <= 1'b0;
         if (wr_en)
            enable_q <= wdata_q[0];
         irq_o <= status_q && enable_q;
      end
   end

   // ===================================================
   // analog carrier
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         analog_o <= '0;
      else
      begin
         analog_o.power <= converter_enable;
         analog_o.channel <= input_channel_field;
         analog_o.sample <= state_q == ACC_CONV && converter_enable;
         analog_o.bit_strobe <= analog_bit_q;
      end
   end

   // ===================================================
   // read channel
   logic [31:0] rd_mux;
   logic rd_hit;
   assign rd_hit = s_araddr_i == ACC_CTRL_ADDR || s_araddr_i == ACC_CLKSEL_ADDR
      || s_araddr_i == ACC_RESULT_ADDR || s_araddr_i == ACC_IRQ_STATUS_ADDR
      || s_araddr_i == ACC_IRQ_ENABLE_ADDR || s_araddr_i == ACC_IRQ_CLEAR_ADDR;
   assign rd_mux = s_araddr_i == ACC_CTRL_ADDR ? {24'h0, ctrl_q} :
                   s_araddr_i == ACC_CLKSEL_ADDR ? {24'h0, clksel_q} :
                   s_araddr_i == ACC_RESULT_ADDR ? {22'h0, result_q} :
                   s_araddr_i == ACC_IRQ_STATUS_ADDR ? {31'h0, status_q} :
                   s_araddr_i == ACC_IRQ_ENABLE_ADDR ? {31'h0, enable_q} :
                   32'h0000_0000;
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_rvalid_o <= 1'b0;
         s_arready_o <= 1'b1;
         s_rdata_o <= 32'h0000_0000;
         s_rresp_o <= ACC_RESP_OKAY;
      end
      else if (s_arvalid_i && s_arready_o)
      begin
         s_rvalid_o <= 1'b1;
         s_arready_o <= 1'b0;
         s_rdata_o <= rd_mux;
         s_rresp_o <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
      else if (s_rready_i)
      begin
         s_rvalid_o <= 1'b0;
         s_arready_o <= 1'b1;
      end
   end
endmodule : acc_top

// ### include/acc_pkg.sv
// package: register map, field layout, timing constants and carrier types of the converter control block
// Contract
// - channel field selects analog input zero..seven
// - codes 000/001/010 divide oscillator 2/8/32
// - codes 100/101 divide oscillator 4/16
// - low bits x11 select internal rc clock
// - unimplemented bits read zero, writes ignored; ctrl bits 7:6 are stored and read back
// - go starts; done clears go, flags, interrupts
// - conversion lasts eleven conversion bit periods
// - reset turns off, aborts, keeps results
package acc_pkg;
   // ===================================================
   // register indices; the bus byte address is four times the index
   localparam logic [7:0] ACC_CTRL_INDEX = 8'h1f;
   localparam logic [7:0] ACC_CLKSEL_INDEX = 8'h9f;
   localparam logic [7:0] ACC_RESULT_INDEX = 8'h20;
   localparam logic [7:0] ACC_IRQ_STATUS_INDEX = 8'h21;
   localparam logic [7:0] ACC_IRQ_ENABLE_INDEX = 8'h22;
   localparam logic [7:0] ACC_IRQ_CLEAR_INDEX = 8'h23;
   // register byte addresses on the bus
   localparam logic [9:0] ACC_CTRL_ADDR = {ACC_CTRL_INDEX, 2'b00};
   localparam logic [9:0] ACC_CLKSEL_ADDR = {ACC_CLKSEL_INDEX, 2'b00};
   localparam logic [9:0] ACC_RESULT_ADDR = {ACC_RESULT_INDEX, 2'b00};
   localparam logic [9:0] ACC_IRQ_STATUS_ADDR = {ACC_IRQ_STATUS_INDEX, 2'b00};
   localparam logic [9:0] ACC_IRQ_ENABLE_ADDR = {ACC_IRQ_ENABLE_INDEX, 2'b00};
   localparam logic [9:0] ACC_IRQ_CLEAR_ADDR = {ACC_IRQ_CLEAR_INDEX, 2'b00};
   // ===================================================
   // field positions
   localparam int ACC_ENABLE_BIT = 0;
   localparam int ACC_GO_BIT = 1;
   localparam int ACC_CHAN_LSB = 2;
   localparam int ACC_CLK_LSB = 4;
   // writable masks (others read zero)
   localparam logic [7:0] ACC_CTRL_MASK = 8'hdf;
   localparam logic [7:0] ACC_CLKSEL_MASK = 8'h70;
   localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
   localparam logic [7:0] ACC_CLKSEL_RESET = 8'h00;
   localparam logic [9:0] ACC_RESULT_RESET = 10'h000;
   // ===================================================
   // timing
   localparam int ACC_CONV_PERIODS = 11;
   localparam int ACC_CLK_MHZ = 250;
   localparam int ACC_RC_KHZ = 500;
   localparam int ACC_RC_HALF = (ACC_CLK_MHZ * 1000 + 2 * ACC_RC_KHZ - 1) / (2 * ACC_RC_KHZ);
   localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
   // ===================================================
   // carrier to the analog macro
   typedef struct packed {
      logic power;
      logic [2:0] channel;
      logic sample;
      logic bit_strobe;
   } acc_analog_t;
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_CONV = 2'b01
   } acc_state_t;
endpackage : acc_pkg

// ### tb/acc_assertions.sv
// checker: bus handshake and converter output relations of the control top
module acc_assertions
   import acc_pkg::*;
#(
   parameter int RC_HALF = 2
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // bus write
   input wire logic [9:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   input wire logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   input wire logic s_wready_o,
   input wire logic [1:0] s_bresp_o,
   input wire logic s_bvalid_o,
   input wire logic s_bready_i,
   // bus read
   input wire logic [9:0] s_araddr_i,
   input wire logic s_arvalid_i,
   input wire logic s_arready_o,
   input wire logic [31:0] s_rdata_o,
   input wire logic [1:0] s_rresp_o,
   input wire logic s_rvalid_o,
   input wire logic s_rready_i,
   // converter side
   input acc_pkg::acc_analog_t analog_o,
   input wire logic [9:0] sar_result_i,
   input wire logic irq_o
);
   // ===================================================
   // properties on the top ports
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // both write channels taken in one cycle
   wire logic both_taken = s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
   resp_delay_a: assert property (both_taken |-> ##2 s_bvalid_o) else $error("late write response");
   bresp_hold_a: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
      else $error("write response dropped");
   rdata_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
      else $error("read data dropped");
   read_answer_a: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o) else $error("late read answer");
   rdata_width_a: assert property (s_rvalid_o |-> s_rdata_o[31:10] == 22'h0) else $error("upper bits set");
   strobe_pulse_a: assert property (analog_o.bit_strobe |=> !analog_o.bit_strobe) else $error("long strobe");
   off_idle_a: assert property (!analog_o.power |-> !analog_o.sample) else $error("sampling while off");
   conv_min_a: assert property ($rose(analog_o.sample) |-> analog_o.sample[*8]) else $error("short run");
   busy_write_a: assert property (both_taken |=> !s_awready_o && !s_wready_o) else $error("write overlap");
endmodule : acc_assertions

bind acc_top acc_assertions #(.RC_HALF(RC_HALF)) u_acc_assertions (.*);

// ### tb/acc_top_tb.sv
// testbench: register access, channel, clock divide, conversion and reset of the control top
module acc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acc_pkg::*;
   // ===================================================
   // signals and design
   localparam int RCH = 2;
   localparam logic [1:0] OK = ACC_RESP_OKAY;
   logic clk_i = 1'b0, resetn_i = 1'b0;
   logic [9:0] s_awaddr_i = 10'h000, s_araddr_i = 10'h000;
   logic [31:0] s_wdata_i = 32'h0, s_rdata_o;
   logic [3:0] s_wstrb_i = 4'hf;
   logic s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0, s_arvalid_i = 0, s_rready_i = 0;
   logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o;
   logic [1:0] s_bresp_o, s_rresp_o;
   logic [9:0] sar_result_i = 10'h0, last_res;
   acc_analog_t analog_o;
   int n_mismatch = 0, checked = 0, seed = 32'ha893e478;
   logic [33:0] exp_q[$];
   acc_top #(.RC_HALF(RCH)) u_acc_top (.*);
   // clock
   always #2 clk_i = ~clk_i;
   // ===================================================
   // compare, verdict and bus tasks
   task chk(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      @(posedge clk_i);
      s_awaddr_i <= a;
      s_wdata_i <= d;
      s_awvalid_i <= 1'b1;
      s_wvalid_i <= 1'b1;
      s_bready_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_awready_o === 1'b1) s_awvalid_i <= 1'b0;
         if (s_wready_o === 1'b1) s_wvalid_i <= 1'b0;
      end while (s_bvalid_o !== 1'b1);
      s_bready_i <= 1'b0;
   endtask : wr
   task rd(input logic [9:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      s_araddr_i <= a;
      s_arvalid_i <= 1'b1;
      s_rready_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (s_arready_o === 1'b1) s_arvalid_i <= 1'b0;
      end while (s_rvalid_o !== 1'b1);
      s_rready_i <= 1'b0;
   endtask : rd
   function int period(input logic [2:0] c);
      case (c)
         3'b000: return 2;
         3'b001: return 8;
         3'b010: return 32;
         3'b100: return 4;
         3'b101: return 16;
         3'b110: return 64;
         default: return 2 * RCH;
      endcase
   endfunction : period
   // one full conversion with clock code c, interrupt enabled for odd codes
   task conv(input logic [2:0] c);
      int n, t, p;
      n = 0;
      t = 0;
      p = 0;
      wr(ACC_CLKSEL_ADDR, {25'h0, c, 4'h0}, OK);
      wr(ACC_IRQ_ENABLE_ADDR, {31'h0, c[0]}, OK);
      sar_result_i <= 10'($random(seed));
      wr(ACC_CTRL_ADDR, {27'h0, c, 2'b11}, OK);
      while (analog_o.sample !== 1'b1) @(posedge clk_i);
      do
      begin
         if (analog_o.bit_strobe === 1'b1)
         begin
            n++;
            p = (n == 1) ? t : (n == 2) ? t - p : p;
         end
         @(posedge clk_i);
         t++;
      end while (analog_o.sample === 1'b1);
      if (analog_o.bit_strobe === 1'b1) n++;
      chk(34'(n), 34'd11);
      chk(34'(p), 34'(period(c)));
      last_res = sar_result_i;
      tick(3);
      chk(34'(irq_o), 34'(c[0]));
      rd(ACC_CTRL_ADDR, {OK, 27'h0, c, 2'b01});
      rd(ACC_IRQ_STATUS_ADDR, {OK, 32'h1});
      rd(ACC_RESULT_ADDR, {OK, 22'h0, last_res});
      wr(ACC_IRQ_CLEAR_ADDR, 32'h1, OK);
      tick(3);
      chk(34'(irq_o), 34'h0);
   endtask : conv
   // ===================================================
   // response monitor: oldest note against each answer
   always @(posedge clk_i)
   begin
      if (s_bvalid_o && s_bready_i) chk({s_bresp_o, 32'h0}, exp_q.pop_front());
      if (s_rvalid_o && s_rready_i) chk({s_rresp_o, s_rdata_o}, exp_q.pop_front());
   end
   // watchdog
   initial
   begin
      #100000;
      n_mismatch++;
      end_of_test;
   end
   // main sequence
   initial
   begin
      logic [31:0] r;
      tick(4);
      resetn_i <= 1'b1;
      tick(4);
      rd(ACC_CTRL_ADDR, {OK, 32'h0});
      rd(ACC_CLKSEL_ADDR, {OK, 32'h0});
      r = $random(seed);
      wr(ACC_CTRL_ADDR, (r | 32'hfe) & 32'hfffffffe, OK);
      rd(ACC_CTRL_ADDR, {OK, 32'hde});
      s_wstrb_i <= 4'he;
      wr(ACC_CTRL_ADDR, 32'h21, OK);
      s_wstrb_i <= 4'hf;
      rd(ACC_CTRL_ADDR, {OK, 32'hde});
      wr(ACC_CLKSEL_ADDR, 32'hffffffff, OK);
      rd(ACC_CLKSEL_ADDR, {OK, 32'h70});
      wr(10'h040, 32'h1, ACC_RESP_SLVERR);
      rd(10'h040, {ACC_RESP_SLVERR, 32'h0});
      for (int i = 0; i < 8; i++)
      begin
         r = $random(seed);
         wr(ACC_CTRL_ADDR, {24'h0, r[7:5], i[2:0], 2'b01}, OK);
         tick(3);
         chk(34'(analog_o.channel), 34'(i[2:0]));
         chk(34'(analog_o.power), 34'h1);
      end
      wr(ACC_CTRL_ADDR, 32'h0, OK);
      tick(3);
      chk(34'(analog_o.power), 34'h0);
      for (int c = 0; c < 8; c++) conv(c[2:0]);
      wr(ACC_CLKSEL_ADDR, 32'h60, OK);
      sar_result_i <= ~last_res;
      wr(ACC_CTRL_ADDR, 32'h03, OK);
      tick(100);
      chk(34'(analog_o.sample), 34'h1);
      wr(ACC_CTRL_ADDR, 32'h01, OK);
      tick(3);
      chk(34'(analog_o.sample), 34'h0);
      rd(ACC_IRQ_STATUS_ADDR, {OK, 32'h0});
      rd(ACC_RESULT_ADDR, {OK, 22'h0, last_res});
      wr(ACC_CTRL_ADDR, 32'h03, OK);
      tick(100);
      resetn_i <= 1'b0;
      tick(2);
      chk(34'({analog_o.power, analog_o.sample}), 34'h0);
      resetn_i <= 1'b1;
      tick(4);
      rd(ACC_CTRL_ADDR, {OK, 32'h0});
      rd(ACC_RESULT_ADDR, {OK, 22'h0, last_res});
      end_of_test;
   end
endmodule : acc_top_tb
